// File: include/cmib_map.svh
// Address map, field positions, reset values and steps of the bus unit
`ifndef CMIB_MAP_SVH
`define CMIB_MAP_SVH

// ==========================================================
// Stack and instruction pointer steps
`define CMIB_SP_STEP 16'h0002
`define CMIB_FETCH_WORD_STEP 16'h0002
`define CMIB_FETCH_BYTE_STEP 16'h0001

// ==========================================================
// Reset values: first fetch lands at the top dedicated area
`define CMIB_RESET_CS 16'hFFFF
`define CMIB_RESET_IP 16'h0000
`define CMIB_RESET_SP 16'h0000
`define CMIB_RESET_WORD 16'h0000

// ==========================================================
// Dedicated physical memory areas
`define CMIB_DED_LOW_END 20'h0007F
`define CMIB_DED_HIGH_BASE 20'hFFFF0

// ==========================================================
// Field positions
`define CMIB_LANE_BIT 0
`define CMIB_IO_UPPER 4'h0

`endif

// File: include/cmib_pkg.sv
// Types shared by the bus unit files
package cmib_pkg;

  // ==========================================================
  // Requests from the execution side
  typedef enum logic [3:0] {
    CMIB_OP_NOP,
    CMIB_OP_MEM_RD,
    CMIB_OP_MEM_WR,
    CMIB_OP_PUSH,
    CMIB_OP_POP,
    CMIB_OP_IO_IN,
    CMIB_OP_IO_OUT,
    CMIB_OP_FETCH,
    CMIB_OP_JUMP,
    CMIB_OP_LOAD_SP,
    CMIB_OP_LOAD_ACC,
    CMIB_OP_LOAD_DX
  } cmib_op_t;

  // ==========================================================
  // Bus sequencer states
  typedef enum logic [1:0] {
    CMIB_ST_IDLE,
    CMIB_ST_START,
    CMIB_ST_WAIT,
    CMIB_ST_HOLD
  } cmib_state_t;

endpackage

// File: design/cmib_sync.sv
// Two-stage synchroniser for the pins that arrive from outside
`timescale 1ns/1ps
`default_nettype none

module cmib_sync #(
  parameter int WIDTH = 18
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Pin side and synchronised side
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  // ==========================================================
  // First stage is read only by the second stage
  logic [WIDTH-1:0] meta_reg;

  // Both stages clear on reset so hold and ready start low
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      meta_reg <= '0;
      pin_sync <= '0;
    end else begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end

endmodule
`default_nettype wire

// File: design/cmib_bus_unit.sv
// Bus interface unit: memory, stack, fetch and I/O cycles with hold hand-over
//
// Contract
// R1 - Push: SP minus two, then write word
// R2 - Pop: read top word, then SP plus two
// R3 - Stack items always move as words
// R4 - Stack pointer wraps inside 64k segment
// R5 - Stack never moves or clears items
// R6 - Low and top areas are dedicated
// R7 - Wide bus: even word in one cycle
// R8 - Wide bus: odd word as two bytes
// R9 - Wide bus fetches even words, odd byte
// R10 - Narrow bus: every access is a byte
// R11 - Separate I/O space, byte or word ports
// R12 - Port data only with the accumulator
// R13 - Port address on low sixteen lines only
// R14 - Port from instruction or data port register
// R15 - Ports F8H to FFH left unused
// R16 - Wide bus moves 8 or 16 I/O bits
// R17 - Byte peripheral registers all even or odd
// R18 - Narrow bus moves one I/O byte per cycle
// R19 - Memory-mapped peripherals behave like memory
// R20 - Hold: finish cycle, then acknowledge
// R21 - No bus cycle while hold is asserted
// R22 - DMA alternates even and odd banks
// R23 - Physical address is segment shifted plus offset
// R24 - Low byte at lower address
// R25 - Stack uses stack segment and pointer
// R26 - Acknowledge drops once hold is withdrawn
`timescale 1ns/1ps
`default_nettype none
`include "cmib_map.svh"

module cmib_bus_unit
  import cmib_pkg::*;
#(
  parameter bit BUS16 = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Request from the execution side
  input wire logic req_valid,
  input wire cmib_op_t req_op,
  input wire logic req_word,
  input wire logic [15:0] req_seg,
  input wire logic [15:0] req_off,
  input wire logic [15:0] req_wdata,
  input wire logic [15:0] stack_seg,
  input wire logic [15:0] req_port_imm,
  input wire logic req_use_dx,
  output logic req_ready,
  // Answer to the execution side
  output logic resp_valid,
  output logic [15:0] resp_data,
  output logic resp_word,
  output logic resp_dedicated,
  // Visible processor state
  output logic [15:0] stack_pointer_reg,
  output logic [15:0] accumulator_word,
  output logic [15:0] data_port_register,
  // External bus
  output logic [19:0] bus_addr,
  output logic bus_bhe_b,
  output logic bus_rd_b,
  output logic bus_wr_b,
  output logic bus_io_sel,
  output logic bus_ctl_oe,
  output logic [15:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic [15:0] bus_data_in,
  input wire logic bus_ready,
  // DMA hand-over
  input wire logic hold_request,
  output logic bus_hold_acknowledge
);

  // ==========================================================
  // Functions
  // Segment shifted four bits plus offset, wrapping at 1M
  function automatic logic [19:0] cmib_phys(input logic [15:0] seg, input logic [15:0] off);
    cmib_phys = {seg, 4'h0} + {4'h0, off}; // [R23]
  endfunction

  // Two byte cycles for odd words, or any word on the narrow bus
  function automatic logic cmib_split(input logic word, input logic [15:0] off);
    cmib_split = word && (!BUS16 || off[`CMIB_LANE_BIT]); // [R8] [R10] [R16] [R18]
  endfunction

  // Dedicated interrupt and reset areas
  function automatic logic cmib_dedicated(input logic [19:0] phys);
    cmib_dedicated = (phys <= `CMIB_DED_LOW_END) || (phys >= `CMIB_DED_HIGH_BASE); // [R6]
  endfunction

  // ==========================================================
  // Declarations
  logic [17:0] pins_sync; // Hold, ready and data after two flops
  logic hold_s; // Synchronised hold request
  logic ready_s; // Synchronised ready
  logic [15:0] din_s; // Synchronised read data
  cmib_state_t state_reg; // Sequencer state
  cmib_state_t state_next;
  cmib_op_t op_reg; // Operation in progress
  logic word_reg; // Operand is a word
  logic two_reg; // Operand takes two byte cycles
  logic io_reg; // Access is in I/O space
  logic idx_reg; // Which byte cycle of a split
  logic busy_reg; // A bus operation is pending
  logic [15:0] seg_reg; // Segment base of the access
  logic [15:0] off_reg; // Offset or port of the first byte
  logic [15:0] wdata_reg; // Data to write
  logic [7:0] rbuf_reg; // Low byte of a split read
  logic [15:0] cs_reg; // Code segment
  logic [15:0] ip_reg; // Fetch pointer
  logic [2:0] strobe_cnt_reg; // Bus cycles of this transfer, for checks
  logic accept; // Request taken this edge
  logic bus_op; // Requested operation needs the bus
  logic wide; // Current cycle moves a whole word
  logic last; // Current cycle ends the transfer
  logic [15:0] off_cur; // Offset of the current cycle
  logic [19:0] addr_cur; // Address of the current cycle
  logic [7:0] lane_in; // Byte read on the active lane
  logic [15:0] read_val; // Assembled read result
  logic done; // Final cycle completes this edge

  // ==========================================================
  // Pin synchroniser
  cmib_sync #(
    .WIDTH(18)
  ) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .pin_in({hold_request, bus_ready, bus_data_in}),
    .pin_sync(pins_sync)
  );

  assign hold_s = pins_sync[17];
  assign ready_s = pins_sync[16];
  assign din_s = pins_sync[15:0];

  // ==========================================================
  // Request decode and cycle geometry
  always_comb begin
    accept = req_valid && req_ready && (state_reg == CMIB_ST_IDLE);
    bus_op = (req_op == CMIB_OP_MEM_RD) || (req_op == CMIB_OP_MEM_WR) ||
             (req_op == CMIB_OP_PUSH) || (req_op == CMIB_OP_POP) ||
             (req_op == CMIB_OP_IO_IN) || (req_op == CMIB_OP_IO_OUT) ||
             (req_op == CMIB_OP_FETCH);
    wide = word_reg && !two_reg; // [R7]
    last = !two_reg || idx_reg;
    // Second byte wraps inside the segment or the port space
    off_cur = off_reg + {15'h0000, idx_reg}; // [R4]
    addr_cur = io_reg ? {`CMIB_IO_UPPER, off_cur} : cmib_phys(seg_reg, off_cur); // [R13]
    lane_in = (BUS16 && bus_addr[`CMIB_LANE_BIT]) ? din_s[15:8] : din_s[7:0];
    // Low byte comes from the lower address
    if (wide) begin
      read_val = din_s;
    end else if (two_reg) begin
      read_val = {lane_in, rbuf_reg}; // [R24]
    end else begin
      read_val = {8'h00, lane_in};
    end
    done = (state_reg == CMIB_ST_WAIT) && ready_s && last;
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CMIB_ST_IDLE: begin
        if (accept && bus_op) begin
          state_next = CMIB_ST_START;
        end else if (!accept && hold_s) begin
          state_next = CMIB_ST_HOLD; // [R20]
        end
      end
      CMIB_ST_START: begin
        // Hold is honoured before a transfer, never between its two halves
        if (!idx_reg && hold_s) begin
          state_next = CMIB_ST_HOLD; // [R21]
        end else if (!ready_s) begin
          state_next = CMIB_ST_WAIT;
        end
      end
      CMIB_ST_WAIT: begin
        if (ready_s) begin
          state_next = last ? CMIB_ST_IDLE : CMIB_ST_START; // [R8]
        end
      end
      CMIB_ST_HOLD: begin
        if (!hold_s) begin
          state_next = busy_reg ? CMIB_ST_START : CMIB_ST_IDLE; // [R21]
        end
      end
      default: begin
        state_next = CMIB_ST_IDLE;
      end
    endcase
  end

  // Sequencer state, request ready and hold acknowledge
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state_reg <= CMIB_ST_IDLE;
      req_ready <= 1'b0;
      bus_hold_acknowledge <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_ready <= (state_next == CMIB_ST_IDLE);
      // Acknowledge only once no cycle runs, dropped as soon as hold goes
      bus_hold_acknowledge <= (state_next == CMIB_ST_HOLD); // [R20] [R26]
    end
  end

  // ==========================================================
  // Operation latch
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      op_reg <= CMIB_OP_NOP;
      word_reg <= 1'b0;
      two_reg <= 1'b0;
      io_reg <= 1'b0;
      busy_reg <= 1'b0;
      seg_reg <= `CMIB_RESET_WORD;
      off_reg <= `CMIB_RESET_WORD;
      wdata_reg <= `CMIB_RESET_WORD;
    end else if (accept && bus_op) begin
      op_reg <= req_op;
      busy_reg <= 1'b1;
      io_reg <= (req_op == CMIB_OP_IO_IN) || (req_op == CMIB_OP_IO_OUT); // [R11]
      case (req_op)
        CMIB_OP_PUSH, CMIB_OP_POP: begin
          // Always a word, addressed by stack segment and pointer
          word_reg <= 1'b1; // [R3]
          seg_reg <= stack_seg; // [R25]
          if (req_op == CMIB_OP_PUSH) begin
            off_reg <= stack_pointer_reg - `CMIB_SP_STEP; // [R1]
            two_reg <= cmib_split(1'b1, stack_pointer_reg - `CMIB_SP_STEP);
          end else begin
            off_reg <= stack_pointer_reg; // [R2]
            two_reg <= cmib_split(1'b1, stack_pointer_reg);
          end
          wdata_reg <= req_wdata;
        end
        CMIB_OP_FETCH: begin
          // Even word on the wide bus, a byte after landing on an odd address
          word_reg <= BUS16 && !ip_reg[`CMIB_LANE_BIT]; // [R9] [R10]
          two_reg <= 1'b0;
          seg_reg <= cs_reg;
          off_reg <= ip_reg;
          wdata_reg <= `CMIB_RESET_WORD;
        end
        CMIB_OP_IO_IN, CMIB_OP_IO_OUT: begin
          word_reg <= req_word;
          seg_reg <= `CMIB_RESET_WORD;
          // Port number from the instruction or from the data port register
          off_reg <= req_use_dx ? data_port_register : req_port_imm; // [R14]
          two_reg <= cmib_split(req_word, req_use_dx ? data_port_register : req_port_imm);
          // Output data only from the accumulator
          wdata_reg <= req_word ? accumulator_word : {8'h00, accumulator_word[7:0]}; // [R12]
        end
        default: begin
          word_reg <= req_word;
          seg_reg <= req_seg;
          off_reg <= req_off;
          two_reg <= cmib_split(req_word, req_off); // [R7] [R8]
          wdata_reg <= req_wdata;
        end
      endcase
    end else if (done) begin
      busy_reg <= 1'b0;
    end
  end

  // Byte cycle index and split read buffer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      idx_reg <= 1'b0;
      rbuf_reg <= 8'h00;
    end else if (accept) begin
      idx_reg <= 1'b0;
    end else if ((state_reg == CMIB_ST_WAIT) && ready_s && !last) begin
      idx_reg <= 1'b1;
      rbuf_reg <= lane_in; // [R24]
    end
  end

  // ==========================================================
  // Stack pointer: only pushes, pops and loads move it
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      stack_pointer_reg <= `CMIB_RESET_SP;
    end else if (accept && (req_op == CMIB_OP_LOAD_SP)) begin
      stack_pointer_reg <= req_wdata; // [R5]
    end else if (accept && (req_op == CMIB_OP_PUSH)) begin
      // Decrement before the write; 16-bit arithmetic wraps in the segment
      stack_pointer_reg <= stack_pointer_reg - `CMIB_SP_STEP; // [R1] [R4]
    end else if (done && (op_reg == CMIB_OP_POP)) begin
      // Increment only after the item has been read
      stack_pointer_reg <= stack_pointer_reg + `CMIB_SP_STEP; // [R2] [R4]
    end
  end

  // Accumulator and data port register
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      accumulator_word <= `CMIB_RESET_WORD;
      data_port_register <= `CMIB_RESET_WORD;
    end else begin
      if (accept && (req_op == CMIB_OP_LOAD_ACC)) begin
        accumulator_word <= req_wdata;
      end else if (done && (op_reg == CMIB_OP_IO_IN)) begin
        // Byte input touches only the low accumulator byte
        if (word_reg) begin
          accumulator_word <= read_val; // [R12]
        end else begin
          accumulator_word <= {accumulator_word[15:8], read_val[7:0]}; // [R12]
        end
      end
      if (accept && (req_op == CMIB_OP_LOAD_DX)) begin
        data_port_register <= req_wdata;
      end
    end
  end

  // Code segment and fetch pointer; reset points at the top dedicated area
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cs_reg <= `CMIB_RESET_CS; // [R6]
      ip_reg <= `CMIB_RESET_IP;
    end else if (accept && (req_op == CMIB_OP_JUMP)) begin
      cs_reg <= req_seg;
      ip_reg <= req_off;
    end else if (done && (op_reg == CMIB_OP_FETCH)) begin
      ip_reg <= ip_reg + (word_reg ? `CMIB_FETCH_WORD_STEP : `CMIB_FETCH_BYTE_STEP); // [R9]
    end
  end

  // ==========================================================
  // Bus pins: address and strobes go out together, released outside cycles
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bus_addr <= 20'h00000;
      bus_bhe_b <= 1'b1;
      bus_rd_b <= 1'b1;
      bus_wr_b <= 1'b1;
      bus_io_sel <= 1'b0;
      bus_ctl_oe <= 1'b0;
      bus_data_out <= 16'h0000;
      bus_data_oe <= 1'b0;
    end else if ((state_reg == CMIB_ST_START) && (state_next == CMIB_ST_WAIT)) begin
      bus_addr <= addr_cur; // [R13] [R23]
      // High lane enabled for word cycles and odd bytes on the wide bus
      bus_bhe_b <= BUS16 ? !(wide || addr_cur[`CMIB_LANE_BIT]) : 1'b1; // [R7] [R10]
      bus_io_sel <= io_reg; // [R11]
      bus_ctl_oe <= 1'b1;
      if ((op_reg == CMIB_OP_MEM_WR) || (op_reg == CMIB_OP_PUSH) ||
          (op_reg == CMIB_OP_IO_OUT)) begin
        bus_wr_b <= 1'b0;
        bus_data_oe <= 1'b1;
        // A single byte is copied to both lanes so either bank sees it
        if (wide) begin
          bus_data_out <= wdata_reg;
        end else if (idx_reg) begin
          bus_data_out <= {wdata_reg[15:8], wdata_reg[15:8]}; // [R24]
        end else begin
          bus_data_out <= {wdata_reg[7:0], wdata_reg[7:0]};
        end
      end else begin
        bus_rd_b <= 1'b0;
      end
    end else if ((state_reg == CMIB_ST_WAIT) && ready_s) begin
      bus_rd_b <= 1'b1;
      bus_wr_b <= 1'b1;
      bus_data_oe <= 1'b0;
      bus_ctl_oe <= !last;
    end else if (state_reg == CMIB_ST_HOLD) begin
      bus_ctl_oe <= 1'b0; // [R20]
      bus_data_oe <= 1'b0;
    end
  end

  // ==========================================================
  // Answer to the execution side
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      resp_valid <= 1'b0;
      resp_data <= 16'h0000;
      resp_word <= 1'b0;
      resp_dedicated <= 1'b0;
    end else if (done) begin
      resp_valid <= 1'b1;
      resp_data <= read_val;
      resp_word <= word_reg;
      // Flags data traffic into areas kept for interrupts and reset
      resp_dedicated <= !io_reg && (op_reg != CMIB_OP_FETCH) &&
                        cmib_dedicated(cmib_phys(seg_reg, off_reg)); // [R6]
    end else if (accept && !bus_op) begin
      resp_valid <= 1'b1;
      resp_data <= req_wdata;
      resp_word <= 1'b1;
      resp_dedicated <= 1'b0;
    end else begin
      resp_valid <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  always_ff @(posedge mclk) begin
    if (!rst_b || accept) begin
      strobe_cnt_reg <= 3'h0;
    end else if ((state_reg == CMIB_ST_START) && (state_next == CMIB_ST_WAIT)) begin
      strobe_cnt_reg <= strobe_cnt_reg + 3'h1;
    end
  end

  property p_push_dec;
    @(posedge mclk) disable iff (!rst_b)
    (accept && req_op == CMIB_OP_PUSH) |=> (stack_pointer_reg == $past(stack_pointer_reg) - 16'h0002);
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not lower SP by two"); // [R1]

  property p_pop_addr;
    @(posedge mclk) disable iff (!rst_b)
    ($fell(bus_rd_b) && op_reg == CMIB_OP_POP && !idx_reg) |->
      (bus_addr == cmib_phys(seg_reg, stack_pointer_reg));
  endproperty
  a_pop_addr: assert property (p_pop_addr) else $error("pop read not at top of stack"); // [R2]

  property p_cycle_count;
    @(posedge mclk) disable iff (!rst_b)
    (done && word_reg && op_reg != CMIB_OP_FETCH) |=>
      (strobe_cnt_reg == ((BUS16 && !off_reg[0]) ? 3'h1 : 3'h2));
  endproperty
  a_cycle_count: assert property (p_cycle_count) else $error("wrong bus cycle count"); // [R8]

  property p_hold_quiet;
    @(posedge mclk) disable iff (!rst_b)
    bus_hold_acknowledge |-> (bus_rd_b && bus_wr_b && !bus_data_oe);
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("bus cycle during hold"); // [R21]

  property p_ack_drop;
    @(posedge mclk) disable iff (!rst_b)
    (bus_hold_acknowledge && !hold_s) |=> !bus_hold_acknowledge;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("acknowledge kept after hold"); // [R26]

  property p_ack_after_cycle;
    @(posedge mclk) disable iff (!rst_b)
    $rose(bus_hold_acknowledge) |-> ($past(bus_rd_b) && $past(bus_wr_b));
  endproperty
  a_ack_after_cycle: assert property (p_ack_after_cycle) else $error("acknowledge mid cycle"); // [R20]

  property p_io_low_lines;
    @(posedge mclk) disable iff (!rst_b)
    (bus_io_sel && !(bus_rd_b && bus_wr_b)) |-> (bus_addr[19:16] == 4'h0);
  endproperty
  a_io_low_lines: assert property (p_io_low_lines) else $error("port address above 16 bits"); // [R13]

  property p_wide_even;
    @(posedge mclk) disable iff (!rst_b)
    (!bus_rd_b && !bus_bhe_b && op_reg == CMIB_OP_FETCH && word_reg) |-> !bus_addr[0];
  endproperty
  a_wide_even: assert property (p_wide_even) else $error("word fetch from odd address"); // [R9]

endmodule
`default_nettype wire

// File: dv/cmib_mem_model.sv
// Partner model: memory and I/O ports answering the bus unit's cycles
`timescale 1ns/1ps
`default_nettype none

module cmib_mem_model (
  // Clock
  input wire logic mclk,
  // Bus from the unit
  input wire logic [19:0] bus_addr,
  input wire logic bus_bhe_b,
  input wire logic bus_rd_b,
  input wire logic bus_wr_b,
  input wire logic bus_io_sel,
  input wire logic [15:0] bus_data_out,
  // Answer to the unit
  output logic [15:0] bus_data_in,
  output logic bus_ready
);
  // ==========================================================
  // Byte store; I/O ports sit above the megabyte so spaces never alias
  logic [7:0] mem [int];
  int wait_cnt = 0;
  int k;

  initial begin
    bus_ready = 1'b0;
    bus_data_in = 16'h0000;
  end

  // ==========================================================
  // Answers like plain memory after a random stall of zero to three cycles
  always @(posedge mclk) begin
    k = {bus_addr[19:1], 1'b0} + (bus_io_sel ? 32'h100000 : 32'h0);
    if (!bus_rd_b || !bus_wr_b) begin
      // Lane enables pick bytes; low byte lives at the even address
      if (!bus_wr_b && !bus_addr[0]) begin
        mem[k] = bus_data_out[7:0];
      end
      if (!bus_wr_b && !bus_bhe_b) begin
        mem[k + 1] = bus_data_out[15:8];
      end
      bus_data_in <= {mem[k + 1], mem[k]};
      if (wait_cnt == 0) begin
        bus_ready <= 1'b1;
      end else begin
        wait_cnt <= wait_cnt - 1;
      end
    end else begin
      // Released bus: ready drops, data wanders so stale values never match
      bus_ready <= 1'b0;
      wait_cnt <= $urandom_range(3, 0);
      bus_data_in <= ~bus_data_in;
    end
  end
endmodule
`default_nettype wire

// File: dv/cmib_bus_unit_tb_top.sv
// Self-checking bench for the bus unit: fetch, stack, memory, I/O and hold
`timescale 1ns/1ps
`default_nettype none

module cmib_bus_unit_tb_top;
  import cmib_pkg::*;
  // ==========================================================
  // Stimulus and design wires
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0, req_word = 1'b0, req_use_dx = 1'b0, hold_request = 1'b0;
  cmib_op_t req_op = CMIB_OP_NOP;
  logic [15:0] req_seg = 16'h0000, req_off = 16'h0000, req_wdata = 16'h0000;
  logic [15:0] stack_seg = 16'h2000, req_port_imm = 16'h0000;
  logic req_ready, resp_valid, resp_word, resp_dedicated, bus_bhe_b, bus_rd_b, bus_wr_b;
  logic bus_io_sel, bus_ctl_oe, bus_data_oe, bus_ready, bus_hold_acknowledge;
  logic [15:0] resp_data, stack_pointer_reg, accumulator_word, data_port_register;
  logic [15:0] bus_data_out, bus_data_in, rd_val, dat, off;
  logic [19:0] bus_addr, last_addr;
  logic prev_strobe = 1'b1;
  int fails = 0, checked = 0, ncyc = 0, cycles = 0;

  // 250 MHz clock
  always #2 mclk = ~mclk;

  cmib_bus_unit u_dut (.mclk(mclk), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
    .req_word(req_word), .req_seg(req_seg), .req_off(req_off), .req_wdata(req_wdata),
    .stack_seg(stack_seg), .req_port_imm(req_port_imm), .req_use_dx(req_use_dx),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_word(resp_word), .resp_dedicated(resp_dedicated),
    .stack_pointer_reg(stack_pointer_reg), .accumulator_word(accumulator_word),
    .data_port_register(data_port_register), .bus_addr(bus_addr), .bus_bhe_b(bus_bhe_b),
    .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b), .bus_io_sel(bus_io_sel),
    .bus_ctl_oe(bus_ctl_oe), .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe),
    .bus_data_in(bus_data_in), .bus_ready(bus_ready), .hold_request(hold_request),
    .bus_hold_acknowledge(bus_hold_acknowledge));

  cmib_mem_model u_mem (.mclk(mclk), .bus_addr(bus_addr), .bus_bhe_b(bus_bhe_b),
    .bus_rd_b(bus_rd_b), .bus_wr_b(bus_wr_b), .bus_io_sel(bus_io_sel),
    .bus_data_out(bus_data_out), .bus_data_in(bus_data_in), .bus_ready(bus_ready));

  // ==========================================================
  // Compare and closing tasks
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ==========================================================
  // Bus watcher: counts cycle starts, notes addresses, cuts a hang short
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    prev_strobe <= bus_rd_b & bus_wr_b;
    if (prev_strobe && !(bus_rd_b & bus_wr_b)) begin
      ncyc <= ncyc + 1;
      last_addr <= bus_addr;
    end
    // Granted bus must be quiet
    if (bus_hold_acknowledge === 1'b1 && (bus_rd_b & bus_wr_b & !bus_ctl_oe) !== 1'b1) begin
      chk(20'h0, 20'h1);
    end
    if (cycles == 20000) begin
      fails++;
      give_verdict();
    end
  end

  // One request: held until taken, then a bounded wait for the answer
  task automatic req(input cmib_op_t op, input logic w, input logic [15:0] seg, o, wd);
    int n;
    req_op = op;
    req_word = w;
    req_seg = seg;
    req_off = o;
    req_wdata = wd;
    req_valid = 1'b1;
    do @(posedge mclk); while (req_ready !== 1'b1);
    #1 req_valid = 1'b0;
    n = 0;
    while (resp_valid !== 1'b1 && n < 200) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n == 200) begin
      chk(20'h0, 20'h1);
    end
    rd_val = resp_data;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hd01e));
    repeat (20) @(posedge mclk);
    #1 rst_b = 1'b1;
    @(posedge mclk);
    #1;
    // Fetch after reset, then an odd jump target gives one byte first
    req(CMIB_OP_FETCH, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(resp_word, 1'b1);
    chk(last_addr, 20'hFFFF0);
    req(CMIB_OP_JUMP, 1'b0, 16'h1000, 16'h0005, 16'h0000);
    req(CMIB_OP_FETCH, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(resp_word, 1'b0);
    chk(last_addr, 20'h10005);
    req(CMIB_OP_FETCH, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(resp_word, 1'b1);
    chk(last_addr, 20'h10006);
    // Push from an empty pointer wraps inside the stack segment
    req(CMIB_OP_LOAD_SP, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    ncyc = 0;
    req(CMIB_OP_PUSH, 1'b0, 16'h0000, 16'h0000, 16'hA55A);
    chk(stack_pointer_reg, 16'hFFFE);
    chk(ncyc, 1);
    chk(last_addr, 20'h2FFFE);
    chk({u_mem.mem[32'h2FFFF], u_mem.mem[32'h2FFFE]}, 16'hA55A);
    req(CMIB_OP_PUSH, 1'b0, 16'h0000, 16'h0000, 16'h1234);
    req(CMIB_OP_POP, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(rd_val, 16'h1234);
    chk(stack_pointer_reg, 16'hFFFE);
    req(CMIB_OP_POP, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    chk(rd_val, 16'hA55A);
    chk(stack_pointer_reg, 16'h0000);
    // Random words, first one at the segment's last byte so the split wraps
    for (int i = 0; i < 8; i++) begin
      off = (i == 0) ? 16'hFFFF : 16'($urandom);
      dat = 16'($urandom);
      req(CMIB_OP_MEM_WR, 1'b1, 16'h3000, off, dat);
      ncyc = 0;
      req(CMIB_OP_MEM_RD, 1'b1, 16'h3000, off, 16'h0000);
      chk(rd_val, dat);
      chk(ncyc, off[0] ? 2 : 1);
      req(CMIB_OP_MEM_RD, 1'b0, 16'h3000, off + 16'h0001, 16'h0000);
      chk(rd_val, {8'h00, dat[15:8]});
    end
    // Edges of the dedicated areas
    req(CMIB_OP_MEM_RD, 1'b0, 16'h0000, 16'h007F, 16'h0000);
    chk(resp_dedicated, 1'b1);
    req(CMIB_OP_MEM_RD, 1'b0, 16'h0000, 16'h0080, 16'h0000);
    chk(resp_dedicated, 1'b0);
    req(CMIB_OP_MEM_RD, 1'b0, 16'hF000, 16'hFFF0, 16'h0000);
    chk(resp_dedicated, 1'b1);
    req(CMIB_OP_MEM_RD, 1'b0, 16'hF000, 16'hFFEF, 16'h0000);
    chk(resp_dedicated, 1'b0);
    // Port traffic through the accumulator; ports F8H to FFH stay unused
    req(CMIB_OP_LOAD_DX, 1'b0, 16'h0000, 16'h0000, 16'h1234);
    req(CMIB_OP_LOAD_ACC, 1'b0, 16'h0000, 16'h0000, 16'hBEEF);
    req_use_dx = 1'b1;
    ncyc = 0;
    req(CMIB_OP_IO_OUT, 1'b1, 16'h7000, 16'h0000, 16'h0000);
    chk(last_addr, 20'h01234);
    chk(ncyc, 1);
    req(CMIB_OP_LOAD_ACC, 1'b0, 16'h0000, 16'h0000, 16'h0000);
    req(CMIB_OP_IO_IN, 1'b1, 16'h7000, 16'h0000, 16'h0000);
    chk(accumulator_word, 16'hBEEF);
    req_use_dx = 1'b0;
    req_port_imm = 16'h1235;
    req(CMIB_OP_IO_IN, 1'b0, 16'h7000, 16'h0000, 16'h0000);
    chk(rd_val, 16'h00BE);
    chk(last_addr, 20'h01235);
    chk(accumulator_word[7:0], 8'hBE);
    // Hold: bus granted, request waits, resumes after release
    hold_request = 1'b1;
    repeat (6) @(posedge mclk);
    #1 chk(bus_hold_acknowledge, 1'b1);
    fork
      req(CMIB_OP_MEM_RD, 1'b1, 16'h3000, 16'h0100, 16'h0000);
      begin
        repeat (10) @(posedge mclk);
        #1 chk(ncyc, 0);
        hold_request = 1'b0;
        repeat (4) @(posedge mclk);
        #1 chk(bus_hold_acknowledge, 1'b0);
      end
      ncyc = 0;
    join
    chk(ncyc, 1);
    give_verdict();
  end
endmodule
`default_nettype wire
